// ### verification/maintenance_monitor_instr_unit_tb.sv
// Self-checking bench for the instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "mmiu_regs.svh"
module maintenance_monitor_instr_unit_tb;
  localparam logic [47:0] BA = 48'h000000123480;
  logic clk_sys, rst_n, issue, monitorMode, jobStart, exchToMon, instDone;
  logic clkEn;
  logic extIntr, memAck, busy, done, bkptFlag, stopReq, undefInst;
  logic extIntrEn, intrBlock, chanFlagSet, memReq, memWrite, arWrite;
  logic [7:0] funcCode, desigR, undefFunc;
  logic [63:0] regR, ctxWord8, ctxBkpt, memRdData, arRdData, memWrData;
  logic [63:0] arWrData;
  logic [47:0] progAddr, undefAddr, memAddr;
  logic [47:0] virtAddr [6];
  logic [47:0] absAddr [6];
  logic [5:0] opValid, refSpecial;
  logic [3:0] parityIn [3];
  logic [3:0] parityOut [3];
  logic [3:0] chanNum, arIndex;
  logic [7:0] mops [4] = '{8'h00, 8'h08, 8'h0C, 8'h0D};
  int errors = 0;
  int n_checks = 0;
  int nWr, nBk, nUd, nCh, nAr, nSt, k;
  mmiu_core dut (.clk_sys, .rst_n, .clkEn, .issue, .funcCode, .desigR,
    .regR, .monitorMode, .ctxWord8, .jobStart, .ctxBkpt, .exchToMon,
    .instDone, .progAddr, .virtAddr, .absAddr, .opValid, .refSpecial,
    .extIntr, .memAck, .memRdData, .arRdData, .parityIn, .parityOut, .busy,
    .done, .bkptFlag, .stopReq, .undefInst, .undefFunc, .undefAddr,
    .extIntrEn, .intrBlock, .chanFlagSet, .chanNum, .memReq, .memWrite,
    .memAddr, .memWrData, .arIndex, .arWrite, .arWrData);
  mmiu_store_model u_store (.clk_sys, .memReq, .memWrite, .memAddr, .arIndex,
    .memAck, .memRdData, .arRdData, .nWr);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Count pulses; stored and loaded words must come in ascending order
  always @(posedge clk_sys)
  begin
    nBk = nBk + (rst_n && bkptFlag);
    nUd = nUd + (rst_n && undefInst);
    nCh = nCh + (rst_n && chanFlagSet);
    if (memReq && memAck && memWrite)
    begin
      chk(memWrData, {60'h0, nSt[3:0]});
      nSt = nSt + 1;
    end
    if (arWrite && funcCode == `MMIU_OP_LDAR)
    begin
      chk(arIndex, nAr[3:0]);
      chk(arWrData, {16'hA5A5, 48'h4000 + 48'h40 * nAr});
      nAr = nAr + 1;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic results;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // Issue one instruction; w cycles of idle wait, below zero no wait
  task automatic op(input logic [7:0] f, input logic [7:0] r,
    input logic [63:0] v, input logic m, input int w);
    int t;
    {funcCode, desigR, regR, monitorMode, issue} = {f, r, v, m, 1'b1};
    tick(1);
    issue = 1'b0;
    if (w > 0)
    begin
      tick(w);
      chk({done, extIntrEn}, 2'b01);
      extIntr = 1'b1;
      tick(1);
      extIntr = 1'b0;
    end
    for (t = 0; t < 300 && w >= 0 && done !== 1'b1; t++)
      tick(1);
    if (t == 300)
    begin
      errors++;
      results();
    end
    tick(1);
  endtask : op
  // One completed instruction with the references set up
  // References are made before completion only, so none leak onward
  task automatic hit(input int exp);
    int n;
    logic [5:0] v;
    n = nBk;
    v = opValid;
    tick(1);
    {instDone, opValid} = {1'b1, 6'h00};
    tick(1);
    instDone = 1'b0;
    tick(2);
    opValid = v;
    chk(nBk - n, exp);
  endtask : hit
  function automatic logic [63:0] bw(input int e);
    bw = 64'h0;
    bw[e] = 1'b1;
    bw[47:5] = BA[47:5];
  endfunction : bw
  initial
  begin
    {rst_n, issue, jobStart, exchToMon, instDone, extIntr} = 6'h00;
    {funcCode, desigR, regR, ctxWord8, ctxBkpt} = '0;
    {monitorMode, progAddr, opValid, refSpecial} = '0;
    {nBk, nUd, nCh, nAr, nSt} = '0;
    clkEn = 1'b1;
    virtAddr = '{default: BA};
    absAddr = '{default: 48'h0};
    parityIn = '{4'h9, 4'h3, 4'h6};
    tick(3);
    rst_n = 1'b1;
    chk({busy, stopReq, intrBlock, parityOut[1]}, 7'h03);
    // Fault test modes set in monitor mode and in permitted job mode, cleared in monitor mode
    op(`MMIU_OP_FTEST, 8'h05, 0, 1, 0);
    for (k = 0; k < 3; k++)
      chk(parityOut[k], parityIn[k] ^ 4'h5);
    chk(intrBlock, 1);
    op(`MMIU_OP_FTEST, 8'h00, 0, 1, 0);
    chk(intrBlock, 0);
    op(`MMIU_OP_FTEST, 8'h0A, 0, 0, 0);
    chk(parityOut[2], parityIn[2]);
    ctxWord8[`MMIU_PERMIT_BIT] = 1'b1;
    op(`MMIU_OP_FTEST, 8'h0A, 0, 0, 0);
    chk(parityOut[2], parityIn[2] ^ 4'hA);
    op(`MMIU_OP_FTEST, 8'h00, 0, 1, 0);
    // Issue held with the clock enable low must not be taken
    {clkEn, issue, funcCode, desigR} = {1'b0, 1'b1, `MMIU_OP_FTEST, 8'h0F};
    tick(2);
    {clkEn, issue} = 2'b10;
    chk({done, intrBlock}, 2'b00);
    // Monitor codes in job mode, then every channel number
    progAddr = 48'h000012345660;
    for (k = 0; k < 4; k++)
    begin
      op(mops[k], 8'h01, 0, 0, 0);
      chk({undefFunc, undefAddr}, {mops[k], progAddr});
    end
    for (k = 0; k < 14; k++)
      op(`MMIU_OP_CHAN, k[7:0], 0, 1, 0);
    chk({nUd, nCh}, {32'd6, 32'd12});
    chk(chanNum, 4'hC);
    // Each operand kind alone, special origin, other kinds
    for (k = 0; k < 6; k++)
    begin
      op(`MMIU_OP_BKPT, 8'h02, bw(53 - k), 1, 0);
      {monitorMode, virtAddr[k], opValid} = {1'b0, BA | 48'h7F, 6'h01 << k};
      hit(1);
      refSpecial = opValid;
      hit(0);
      {refSpecial, opValid} = {6'h00, ~(6'h01 << k)};
      hit(0);
      opValid = 6'h00;
    end
    op(`MMIU_OP_BKPT, 8'h02, bw(53), 1, 0);
    opValid = 6'h01;
    hit(0);
    absAddr[0] = BA;
    hit(1);
    opValid = 6'h00;
    op(`MMIU_OP_BKPT, 8'h02, bw(54), 1, 0);
    progAddr = BA | 48'h1F;
    hit(1);
    progAddr = BA + 48'h20;
    hit(0);
    progAddr = BA;
    exchToMon = 1'b1;
    tick(1);
    exchToMon = 1'b0;
    hit(0);
    {ctxBkpt, jobStart} = {bw(54), 1'b1};
    tick(1);
    jobStart = 1'b0;
    hit(1);
    // Associative registers out and back, idle, stop
    op(`MMIU_OP_STAR, 8'h00, 0, 1, 0);
    chk(nWr, 16);
    op(`MMIU_OP_LDAR, 8'h00, 0, 1, 0);
    chk(nAr, 16);
    op(`MMIU_OP_IDLE, 8'h00, 0, 1, 5);
    op(`MMIU_OP_BKPT, 8'h00, 0, 1, -1);
    chk(stopReq, 1);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    chk(stopReq, 0);
    results();
  end
endmodule : maintenance_monitor_instr_unit_tb
`default_nettype wire

// ### verification/mmiu_core_monitor.sv
// Checker bound to the instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "mmiu_regs.svh"
module mmiu_core_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic clkEn, // Clock enable
  input wire logic issue, // Issue
  input wire logic busy, // Busy
  input wire logic [7:0] funcCode, // Code
  input wire logic [7:0] desigR, // Designator
  input wire logic monitorMode, // Mode
  input wire logic instDone, // Done
  input wire logic [3:0] parityIn [3], // Raw
  input wire logic [3:0] parityOut [3], // Seen
  input wire logic bkptFlag, // Match
  input wire logic stopReq, // Halt
  input wire logic undefInst, // Undefined
  input wire logic extIntrEn, // Int on
  input wire logic intrBlock, // Lockout
  input wire logic chanFlagSet, // Flag
  input wire logic [3:0] chanNum, // Channel
  input wire logic memReq, // Request
  input wire logic memAck, // Accept
  input wire logic memWrite, // Write
  input wire logic [47:0] memAddr // Address
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Accepted instruction and the monitor-only codes
  wire logic taken = issue && !busy && clkEn;
  wire logic monOp = funcCode == `MMIU_OP_IDLE || funcCode == `MMIU_OP_CHAN
    || funcCode == `MMIU_OP_STAR || funcCode == `MMIU_OP_LDAR;
  // Timing and value relations at the ports
  AST_PAR_PASS: assert property (
    !intrBlock |-> parityOut[0] == parityIn[0] && parityOut[2] == parityIn[2])
    else $error("parity altered with no test mode");
  AST_BKPT_LATE: assert property ($past(rst_n) && bkptFlag
    |-> $past(instDone)) else $error("match flag before completion");
  AST_STOP: assert property (
    taken && funcCode == `MMIU_OP_BKPT && desigR == 8'h00 |=> stopReq)
    else $error("zero designator did not stop");
  AST_UNDEF_JOB: assert property (
    taken && !monitorMode && monOp |=> undefInst)
    else $error("monitor code in job mode not undefined");
  AST_CHAN_RANGE: assert property (
    chanFlagSet |-> chanNum >= 4'h1 && chanNum <= 4'hC)
    else $error("flag set on missing channel");
  AST_AR_RANGE: assert property (
    memReq |-> memAddr[5:0] == 6'h00 && memAddr >= 48'h4000
    && memAddr <= 48'h43C0) else $error("storage address out of area");
  AST_AR_STEP: assert property (
    memReq && memAck ##1 memReq |-> memAddr == $past(memAddr) + 48'h40)
    else $error("storage address not ascending");
  AST_IDLE: assert property (
    taken && monitorMode && funcCode == `MMIU_OP_IDLE |-> ##[1:2] extIntrEn)
    else $error("idle did not enable interrupt");
  // Main scenarios reached
  cover property (bkptFlag);
  cover property (chanFlagSet);
  cover property (memReq && memAck && memWrite);
endmodule : mmiu_core_monitor
bind mmiu_core mmiu_core_monitor u_mon (.clk_sys, .rst_n, .clkEn, .issue,
  .busy,
  .funcCode, .desigR, .monitorMode, .instDone, .parityIn, .parityOut,
  .bkptFlag, .stopReq, .undefInst, .extIntrEn, .intrBlock, .chanFlagSet,
  .chanNum, .memReq, .memAck, .memWrite, .memAddr);
`default_nettype wire

// ### verification/mmiu_store_model.sv
// Storage and associative register model
`timescale 1ns/1ps
`default_nettype none
module mmiu_store_model (
  input wire logic clk_sys, // Clock
  input wire logic memReq, // Request
  input wire logic memWrite, // Write
  input wire logic [47:0] memAddr, // Address
  input wire logic [3:0] arIndex, // Register
  output logic memAck, // Accept
  output logic [63:0] memRdData, // Read word
  output logic [63:0] arRdData, // Register word
  output int nWr // Writes taken
);
  logic waitFf;
  // Registers read back their own index
  assign arRdData = {60'h0, arIndex};
  initial
  begin
    {memAck, waitFf} = 2'b00;
    memRdData = 64'h0;
    nWr = 0;
  end
  // Answer at once or a cycle late, alternating by address
  always @(posedge clk_sys)
  begin
    memAck <= 1'b0;
    memRdData <= ~memRdData; // Last word inverted every cycle between answers
    if (memReq && !memAck && waitFf)
      waitFf <= 1'b0;
    else if (memReq && !memAck)
    begin
      memAck <= 1'b1;
      memRdData <= {16'hA5A5, memAddr};
      waitFf <= memAddr[6];
      nWr <= nWr + memWrite;
    end
  end
endmodule : mmiu_store_model
`default_nettype wire

// ### verilog/mmiu_addr_cmp.sv
// One breakpoint comparator for one reference kind
`timescale 1ns/1ps
`default_nettype none
`include "mmiu_regs.svh"
module mmiu_addr_cmp #(
  parameter int DROP = 7
) (
  input wire logic [47:0] refAddr, // Bit address of the reference
  input wire logic refValid, // Reference made this instruction
  input wire logic [47:0] bkptAddr, // Breakpoint address, bit aligned
  input wire logic enable, // Usage enable for this kind
  output logic hit // Match found
);
  // Compare above the granularity boundary only
  wire logic [47-DROP:0] refHi = refAddr[47:DROP];
  wire logic [47-DROP:0] bkHi = bkptAddr[47:DROP];
  assign hit = enable && refValid && (refHi == bkHi);
endmodule : mmiu_addr_cmp
`default_nettype wire

// ### verilog/mmiu_core.sv
// Maintenance and monitor-only instruction unit
`timescale 1ns/1ps
`default_nettype none
`include "mmiu_regs.svh"
module mmiu_core #(
  parameter int AR_WIDTH = 64
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic clkEn, // Clock enable, freezes state when low
  input wire logic issue, // Instruction issued to this unit
  input wire logic [7:0] funcCode, // Function code F
  input wire logic [7:0] desigR, // R designator
  input wire logic [63:0] regR, // Content of register named by R
  input wire logic monitorMode, // High in monitor mode
  input wire logic [63:0] ctxWord8, // Saved context word 8 of the job
  input wire logic jobStart, // Exchange into a job
  input wire logic [63:0] ctxBkpt, // Saved breakpoint from job context
  input wire logic exchToMon, // Exchange into monitor mode
  input wire logic instDone, // Current instruction has completed
  input wire logic [47:0] progAddr, // Program address of instruction
  input wire logic [47:0] virtAddr [6], // Operand addresses, job mode
  input wire logic [47:0] absAddr [6], // Operand addresses, monitor mode
  input wire logic [5:0] opValid, // Operand reference made, per kind
  input wire logic [5:0] refSpecial, // Search or channel origin, per kind
  input wire logic extIntr, // External interrupt request
  input wire logic memAck, // Storage accepted the transfer
  input wire logic [AR_WIDTH-1:0] memRdData, // Word read from storage
  input wire logic [AR_WIDTH-1:0] arRdData, // Associative register read
  input wire logic [3:0] parityIn [3], // Raw parity per half-word per bus
  output logic [3:0] parityOut [3], // Parity seen by the checkers
  output logic busy, // Unit holds the issue path
  output logic done, // Instruction finished, one cycle
  output logic bkptFlag, // Pulse setting data flag bit 47
  output logic stopReq, // Instruction processing halted
  output logic undefInst, // Treat as undefined instruction, pulse
  output logic [7:0] undefFunc, // Function code saved on undefined
  output logic [47:0] undefAddr, // Program address saved on undefined
  output logic extIntrEn, // External interrupt enabled
  output logic intrBlock, // Interrupts and I/O requests refused
  output logic chanFlagSet, // Channel flag set pulse
  output logic [3:0] chanNum, // Channel of the last in-range channel instruction, in either mode
  output logic memReq, // Storage request
  output logic memWrite, // Storage request is a write
  output logic [47:0] memAddr, // Absolute storage address
  output logic [AR_WIDTH-1:0] memWrData, // Word written to storage
  output logic [3:0] arIndex, // Associative register selected
  output logic arWrite, // Write associative register
  output logic [AR_WIDTH-1:0] arWrData // Associative register data
);
  import mmiu_pkg::*;

  // Registered state and output holding stages
  logic [63:0] bkptReg_ff; // breakpoint_match_register
  logic [3:0] faultMode_ff;
  mmiu_state_t state_ff;
  mmiu_state_t nxt_state;
  logic storeDir_ff;
  logic [4:0] arCnt_ff;
  logic [47:0] arAddr_ff;
  logic done_ff, bkptFlag_ff, stop_ff, undef_ff, ieEn_ff;
  logic chanSet_ff;
  logic [3:0] chanNum_ff;
  logic [7:0] undefFunc_ff;
  logic [47:0] undefAddr_ff;
  logic [AR_WIDTH-1:0] wrData_ff;
  logic [AR_WIDTH-1:0] arWrData_ff;
  logic arWrite_ff;
  logic hitHold_ff;

  // Decode of the issued instruction
  wire logic isIdle = issue && funcCode == `MMIU_OP_IDLE;
  wire logic isBkpt = issue && funcCode == `MMIU_OP_BKPT;
  wire logic isFtest = issue && funcCode == `MMIU_OP_FTEST;
  wire logic isChan = issue && funcCode == `MMIU_OP_CHAN;
  wire logic isStar = issue && funcCode == `MMIU_OP_STAR;
  wire logic isLdar = issue && funcCode == `MMIU_OP_LDAR;
  wire logic isMonOnly = isIdle || isChan || isStar || isLdar;
  wire logic accept = issue && state_ff == MMIU_IDLE;
  wire logic monFault = accept && isMonOnly && !monitorMode;
  wire logic chanOk = desigR >= `MMIU_CHAN_MIN &&
                      desigR <= `MMIU_CHAN_MAX;
  wire logic chanBad = accept && isChan && monitorMode && !chanOk;
  wire logic ftPermit = monitorMode ||
                        ctxWord8[`MMIU_PERMIT_BIT];
  wire logic ftDo = accept && isFtest && ftPermit;
  wire logic bkStop = accept && isBkpt && desigR == 8'h00;
  wire logic bkLoad = accept && isBkpt && desigR != 8'h00;
  wire logic idleGo = accept && isIdle && monitorMode;
  wire logic arGo = accept && (isStar || isLdar) && monitorMode;

  // Breakpoint fields
  wire logic [6:0] usageEn = bkptReg_ff[`MMIU_EN_LSB:`MMIU_EN_MSB];
  // Address field stays in place; low half-word bits read as zero
  wire logic [47:0] bkAddr = {bkptReg_ff[`MMIU_ADDR_MSB:`MMIU_ADDR_LSB],
    5'h00};
  // Comparator results, one per operand kind and one for the program
  wire logic [5:0] opHit;
  wire logic progHit;

  // Program address compared on half-word granularity
  mmiu_addr_cmp #(.DROP(`MMIU_HW_DROP)) uProg (
    .refAddr(progAddr),
    .refValid(instDone),
    .bkptAddr(bkAddr),
    .enable(usageEn[6]),
    .hit(progHit)
  );

  // Operand kinds A, B, C, Z, X, Y on sword granularity
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : gOp
      wire logic [47:0] selAddr = monitorMode ? absAddr[gi] :
                                  virtAddr[gi];
      wire logic okRef = opValid[gi] && !refSpecial[gi];
      mmiu_addr_cmp #(.DROP(`MMIU_SW_DROP)) uOp (
        .refAddr(selAddr),
        .refValid(okRef),
        .bkptAddr(bkAddr),
        .enable(usageEn[5-gi]),
        .hit(opHit[gi])
      );
    end
  endgenerate

  // Any enabled operand kind; the flag waits for completion
  wire logic anyOpHit = |opHit;
  wire logic raiseBk = instDone && (progHit || anyOpHit ||
                       hitHold_ff);

  // Parity inversion per half-word on every read bus
  generate
    for (gi = 0; gi < 3; gi++)
    begin : gPar
      assign parityOut[gi] = parityIn[gi] ^ faultMode_ff;
    end
  endgenerate

  // Associative register transfer sequencing
  wire logic arLast = arCnt_ff == (`MMIU_AR_COUNT - 5'h01);
  wire logic xferStep = state_ff == MMIU_XFER && memAck;

  // Next state of the sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      MMIU_IDLE:
      begin
        if (idleGo)
          nxt_state = MMIU_WAIT;
        else if (arGo)
          nxt_state = MMIU_XFER;
        else if (bkStop)
          nxt_state = MMIU_STOP;
      end
      MMIU_WAIT:
        if (extIntr)
          nxt_state = MMIU_IDLE;
      MMIU_XFER:
        if (xferStep && arLast)
          nxt_state = MMIU_IDLE;
      MMIU_STOP:
        nxt_state = MMIU_STOP;
      default:
        nxt_state = MMIU_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_ff <= MMIU_IDLE;
    else if (clkEn)
      state_ff <= nxt_state;
  end

  // Breakpoint register load, restore and clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bkptReg_ff <= 64'h0000000000000000;
    else if (clkEn)
    begin
      if (exchToMon)
        bkptReg_ff <= 64'h0000000000000000;
      else if (jobStart)
        bkptReg_ff <= ctxBkpt;
      else if (bkLoad)
        bkptReg_ff <= regR;
    end
  end

  // Operand hits held until the instruction completes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      hitHold_ff <= 1'b0;
    else if (clkEn)
      hitHold_ff <= !instDone && (hitHold_ff || anyOpHit);
  end

  // Breakpoint flag pulse after completion
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bkptFlag_ff <= 1'b0;
    else if (clkEn)
      bkptFlag_ff <= raiseBk;
  end

  // Fault test modes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      faultMode_ff <= 4'h0;
    else if (clkEn && ftDo)
      faultMode_ff <= desigR[3:0];
  end

  // Completion, undefined and channel pulses, and the stop latch held until reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      done_ff <= 1'b0;
      undef_ff <= 1'b0;
      stop_ff <= 1'b0;
      chanSet_ff <= 1'b0;
      chanNum_ff <= 4'h0;
    end
    else if (clkEn)
    begin
      done_ff <= (accept && !idleGo && !arGo && !bkStop) ||
                 (state_ff == MMIU_WAIT && extIntr) ||
                 (xferStep && arLast);
      undef_ff <= monFault || chanBad;
      stop_ff <= stop_ff || bkStop;
      chanSet_ff <= accept && isChan && monitorMode && chanOk;
      if (accept && isChan && chanOk)
        chanNum_ff <= desigR[3:0];
    end
  end

  // Saved function code and program address for undefined
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      undefFunc_ff <= 8'h00;
      undefAddr_ff <= 48'h000000000000;
    end
    else if (clkEn && (monFault || chanBad))
    begin
      undefFunc_ff <= funcCode;
      undefAddr_ff <= progAddr;
    end
  end

  // Idle interrupt enable
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ieEn_ff <= 1'b0;
    else if (clkEn)
      ieEn_ff <= nxt_state == MMIU_WAIT;
  end

  // Associative transfer counter and address
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      arCnt_ff <= 5'h00;
      arAddr_ff <= 48'h000000000000;
      storeDir_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      if (arGo)
      begin
        arCnt_ff <= 5'h00;
        arAddr_ff <= `MMIU_AR_BASE;
        storeDir_ff <= isStar;
      end
      else if (xferStep)
      begin
        arCnt_ff <= arCnt_ff + 5'h01;
        arAddr_ff <= arAddr_ff + `MMIU_AR_STEP;
      end
    end
  end

  // Load path writes registers from storage
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      arWrite_ff <= 1'b0;
      arWrData_ff <= '0;
      wrData_ff <= '0;
    end
    else if (clkEn)
    begin
      arWrite_ff <= xferStep && !storeDir_ff;
      if (xferStep)
        arWrData_ff <= memRdData;
      wrData_ff <= arRdData;
    end
  end

  // Register index lags the storage step by the write stage
  logic [3:0] arWrIdx_ff;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      arWrIdx_ff <= 4'h0;
    else if (clkEn && xferStep)
      arWrIdx_ff <= arCnt_ff[3:0];
  end

  // Outputs
  assign busy = state_ff != MMIU_IDLE;
  assign done = done_ff;
  assign bkptFlag = bkptFlag_ff;
  assign stopReq = stop_ff;
  assign undefInst = undef_ff;
  assign undefFunc = undefFunc_ff;
  assign undefAddr = undefAddr_ff;
  assign extIntrEn = ieEn_ff;
  assign intrBlock = |faultMode_ff;
  assign chanFlagSet = chanSet_ff;
  assign chanNum = chanNum_ff;
  assign memReq = state_ff == MMIU_XFER;
  assign memWrite = storeDir_ff;
  assign memAddr = arAddr_ff;
  assign memWrData = wrData_ff;
  assign arIndex = arWrite_ff ? arWrIdx_ff : arCnt_ff[3:0];
  assign arWrite = arWrite_ff;
  assign arWrData = arWrData_ff;
endmodule : mmiu_core
`default_nettype wire

// ### verilog/mmiu_pkg.sv
// Types for the maintenance and monitor instruction unit
package mmiu_pkg;
  typedef enum logic [3:0] {
    MMIU_IDLE = 4'h1,
    MMIU_WAIT = 4'h2,
    MMIU_XFER = 4'h4,
    MMIU_STOP = 4'h8
  } mmiu_state_t;
endpackage : mmiu_pkg

// ### verilog/mmiu_regs.svh
// Constants for the maintenance and monitor instruction unit
`ifndef MMIU_REGS_SVH
`define MMIU_REGS_SVH
`define MMIU_OP_IDLE 8'h00
`define MMIU_OP_BKPT 8'h04
`define MMIU_OP_FTEST 8'h06
`define MMIU_OP_CHAN 8'h08
`define MMIU_OP_STAR 8'h0C
`define MMIU_OP_LDAR 8'h0D
`define MMIU_EN_LSB 54
`define MMIU_EN_MSB 48
`define MMIU_ADDR_MSB 47
`define MMIU_ADDR_LSB 5
`define MMIU_HW_DROP 5
`define MMIU_SW_DROP 7
`define MMIU_FT_LSB 0
`define MMIU_PERMIT_BIT 50
`define MMIU_AR_BASE 48'h000000004000
`define MMIU_AR_STEP 48'h000000000040
`define MMIU_AR_COUNT 5'h10
`define MMIU_CHAN_MIN 8'h01
`define MMIU_CHAN_MAX 8'h0C
`endif
